// file: rtl/hpp_pkg.sv
// ****************************************
// shared constants and types
// ****************************************
package hpp_pkg;
  localparam int HPP_AW = 11;
  localparam int HPP_DW = 8;
  // lowest address pin still used in multiplexed mode
  localparam int HPP_MUX_HI = 8;
  // serial frame: direction bit, address, data
  localparam logic [4:0] HPP_SER_HDR = 5'h0C;
  localparam logic [4:0] HPP_SER_ALL = 5'h14;
  localparam logic HPP_PS_SERIAL = 1'b0;
  localparam logic HPP_STYLE_DSTB = 1'b0;
  localparam logic HPP_MUX_SEPARATE = 1'b0;
  localparam logic HPP_SER_READ = 1'b1;
  localparam logic [7:0] HPP_BUS_FLOAT = 8'hFF;
  // host clock period, shift clock and strobe phase length
  localparam int HPP_CLK_NS = 8;
  localparam int HPP_HALF_NS = 64;
  localparam int HPP_HALF_CYC = (HPP_HALF_NS + HPP_CLK_NS - 1) / HPP_CLK_NS;

  // device pin sample, as seen after the synchroniser
  typedef struct packed {
    logic cs_n;
    logic ps;
    logic style;
    logic mux;
    logic as_n;
    logic stb;
    logic dir;
    logic [HPP_AW-1:0] addr;
    logic [HPP_DW-1:0] data;
  } hpp_pins_s;

  typedef enum logic [1:0] {
    HPP_D_IDLE = 2'b00,
    HPP_D_RD_WAIT = 2'b01,
    HPP_D_RD_HOLD = 2'b10,
    HPP_D_WR_HOLD = 2'b11
  } hpp_dev_state_e;

  typedef enum logic [2:0] {
    HPP_H_IDLE = 3'b000,
    HPP_H_ADDR = 3'b001,
    HPP_H_LATCH = 3'b010,
    HPP_H_DATA = 3'b011,
    HPP_H_STROBE = 3'b100,
    HPP_H_END = 3'b101,
    HPP_H_SER = 3'b110
  } hpp_host_state_e;
endpackage : hpp_pkg

// file: rtl/hpp_if.sv
`timescale 1ns/1ps
// ****************************************
// pins between host and device
// ****************************************
interface hpp_if;
  import hpp_pkg::*;
  logic cs_n;
  logic port_style_sel;
  logic bus_style_select;
  logic mux_bus_select;
  logic address_strobe_n;
  // shift clock, read strobe or data strobe
  logic clk_strobe;
  // serial input, write strobe or direction
  logic serial_in_dir;
  // serial output, acknowledge or ready
  logic serial_out_resp;
  logic [HPP_AW-1:0] addr;
  logic [HPP_DW-1:0] dev_d_o;
  logic dev_d_oe;
  logic [HPP_DW-1:0] host_d_o;
  logic host_d_oe;
  logic [HPP_DW-1:0] data_bus;

  // resolved level of the shared data lines
  assign data_bus = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : HPP_BUS_FLOAT);

  modport device (
    input cs_n, port_style_sel, bus_style_select, mux_bus_select, address_strobe_n,
    input clk_strobe, serial_in_dir, addr, data_bus,
    output serial_out_resp, dev_d_o, dev_d_oe
  );
  modport host (
    output cs_n, port_style_sel, bus_style_select, mux_bus_select, address_strobe_n,
    output clk_strobe, serial_in_dir, addr, host_d_o, host_d_oe,
    input serial_out_resp, data_bus
  );
endinterface : hpp_if

// file: rtl/hpp_device_end.sv
`timescale 1ns/1ps
// Behaviour
// - mux pin grounded: separate address/data buses
// - strobe-pair mux: address latched on ALE fall
// - data-strobe mux: address latched on address strobe fall
// - host holds address strobe high when separate
// - serial: address then data, sampled rising
// - serial output changes on falling shift clock
// - data strobe low: direction picks capture/drive
// - host: direction low write, high read
// - read strobe low: device drives register data
// - write strobe low: device takes data bus
// - acknowledge low when data valid or taken
// - ready low for waits, high to complete
// - mux: data lines carry address then data
// - serial: board grounds parallel pins
// - host frames every access with chip select
// - style pin grounded selects serial interface
// - bus style pin grounded: data-strobe style
module hpp_device_end
  import hpp_pkg::*;
(
  hpp_if.device pins,
  input logic clk,
  input logic rst,
  output logic reg_rd,
  output logic reg_wr,
  output logic [HPP_AW-1:0] reg_addr,
  output logic [HPP_DW-1:0] reg_wdata,
  input logic [HPP_DW-1:0] reg_rdata
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  hpp_pins_s raw;
  hpp_pins_s sync1_reg;
  hpp_pins_s s;
  hpp_pins_s prev_reg;
  logic as_fall;
  logic stb_rise;
  logic stb_fall;

  // gather every input pin into one sample
  assign raw = '{cs_n: pins.cs_n, ps: pins.port_style_sel, style: pins.bus_style_select,
                 mux: pins.mux_bus_select, as_n: pins.address_strobe_n, stb: pins.clk_strobe,
                 dir: pins.serial_in_dir, addr: pins.addr, data: pins.data_bus};

  // two flops, then one more stage for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= '1;
      s <= '1;
      prev_reg <= '1;
    end
    else
    begin
      sync1_reg <= raw;
      s <= sync1_reg;
      prev_reg <= s;
    end
  end

  // edges seen on synchronised pins only
  assign as_fall = prev_reg.as_n & ~s.as_n;
  assign stb_rise = ~prev_reg.stb & s.stb;
  assign stb_fall = prev_reg.stb & ~s.stb;

  // ****************************************
  // parallel styles
  // ****************************************
  hpp_dev_state_e st_reg;
  hpp_dev_state_e st_next;
  logic par_mode;
  logic dstb_style;
  logic rd_start;
  logic wr_start;
  logic cyc_idle;
  logic par_rd;
  logic par_wr;
  logic [HPP_AW-1:0] cur_addr;
  logic [HPP_AW-1:0] ale_addr_reg;
  logic [HPP_AW-1:0] ale_addr_next;
  logic [HPP_DW-1:0] dout_reg;
  logic [HPP_DW-1:0] dout_next;
  logic oe_reg;
  logic oe_next;
  logic resp_reg;
  logic resp_next;

  // parallel cycle decode and sequencing
  always_comb
  begin
    par_mode = (s.ps != HPP_PS_SERIAL);
    // bus style pin selects strobe style
    dstb_style = (s.style == HPP_STYLE_DSTB);
    cur_addr = (s.mux == HPP_MUX_SEPARATE) ? s.addr : ale_addr_reg;
    rd_start = dstb_style ? (~s.stb & s.dir) : 1'b0;
    wr_start = dstb_style ? (~s.stb & ~s.dir) : 1'b0;
    // read strobe low starts a read
    if (!dstb_style)
    begin
      rd_start = ~s.stb;
      // write strobe low starts a write
      wr_start = ~s.dir;
    end
    cyc_idle = s.cs_n | (dstb_style ? s.stb : (s.stb & s.dir));
    ale_addr_next = ale_addr_reg;
    // latch upper pins and data lines on strobe fall
    if (s.mux != HPP_MUX_SEPARATE && as_fall)
    begin
      ale_addr_next = {s.addr[HPP_AW-1:HPP_MUX_HI], s.data};
    end
    st_next = st_reg;
    dout_next = dout_reg;
    par_rd = 1'b0;
    par_wr = 1'b0;
    case (st_reg)
      HPP_D_IDLE:
      begin
        if (par_mode && !s.cs_n && rd_start)
        begin
          par_rd = 1'b1;
          st_next = HPP_D_RD_WAIT;
        end
        else if (par_mode && !s.cs_n && wr_start)
        begin
          // data bus taken at strobe start
          par_wr = 1'b1;
          st_next = HPP_D_WR_HOLD;
        end
      end
      HPP_D_RD_WAIT:
      begin
        dout_next = reg_rdata;
        st_next = HPP_D_RD_HOLD;
      end
      HPP_D_RD_HOLD:
      begin
        if (cyc_idle)
        begin
          st_next = HPP_D_IDLE;
        end
      end
      HPP_D_WR_HOLD:
      begin
        if (cyc_idle)
        begin
          st_next = HPP_D_IDLE;
        end
      end
      default:
      begin
        st_next = HPP_D_IDLE;
      end
    endcase
    // drive the bus only while a read is held
    oe_next = (st_next == HPP_D_RD_HOLD);
    resp_next = (st_next == HPP_D_RD_HOLD) || (st_next == HPP_D_WR_HOLD);
  end

  // parallel state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= HPP_D_IDLE;
      ale_addr_reg <= '0;
      dout_reg <= '0;
      oe_reg <= 1'b0;
      resp_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      ale_addr_reg <= ale_addr_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      resp_reg <= resp_next;
    end
  end

  // ****************************************
  // serial interface
  // ****************************************
  logic [4:0] sc_reg;
  logic [4:0] sc_next;
  logic [HPP_SER_ALL-1:0] ssh_reg;
  logic [HPP_SER_ALL-1:0] ssh_next;
  logic [HPP_SER_ALL-1:0] sh_new;
  logic [HPP_DW-1:0] osh_reg;
  logic [HPP_DW-1:0] osh_next;
  logic sdo_reg;
  logic sdo_next;
  logic srd_reg;
  logic srd_next;
  logic sload_reg;
  logic ser_rd;
  logic ser_wr;
  logic [HPP_AW-1:0] ser_addr;

  // shift in on rising clock, out on falling
  always_comb
  begin
    sh_new = {ssh_reg[HPP_SER_ALL-2:0], s.dir};
    sc_next = sc_reg;
    ssh_next = ssh_reg;
    osh_next = osh_reg;
    sdo_next = sdo_reg;
    srd_next = srd_reg;
    ser_rd = 1'b0;
    ser_wr = 1'b0;
    ser_addr = sh_new[HPP_AW+HPP_DW-1:HPP_DW];
    if (sload_reg)
    begin
      osh_next = reg_rdata;
    end
    if (par_mode || s.cs_n)
    begin
      sc_next = '0;
      srd_next = 1'b0;
      sdo_next = 1'b0;
    end
    else
    begin
      // sample serial input on rising shift clock
      if (stb_rise && sc_reg != HPP_SER_ALL)
      begin
        ssh_next = sh_new;
        sc_next = sc_reg + 5'h01;
        if (sc_reg == HPP_SER_HDR - 5'h01 && sh_new[HPP_AW] == HPP_SER_READ)
        begin
          ser_rd = 1'b1;
          srd_next = 1'b1;
          ser_addr = sh_new[HPP_AW-1:0];
        end
        if (sc_reg == HPP_SER_ALL - 5'h01 && sh_new[HPP_AW+HPP_DW] != HPP_SER_READ)
        begin
          ser_wr = 1'b1;
        end
      end
      // next read bit on falling shift clock
      if (stb_fall && srd_reg && sc_reg >= HPP_SER_HDR)
      begin
        sdo_next = osh_reg[HPP_DW-1];
        osh_next = {osh_reg[HPP_DW-2:0], 1'b0};
      end
    end
  end

  // serial state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sc_reg <= '0;
      ssh_reg <= '0;
      osh_reg <= '0;
      sdo_reg <= 1'b0;
      srd_reg <= 1'b0;
      sload_reg <= 1'b0;
    end
    else
    begin
      sc_reg <= sc_next;
      ssh_reg <= ssh_next;
      osh_reg <= osh_next;
      sdo_reg <= sdo_next;
      srd_reg <= srd_next;
      sload_reg <= ser_rd;
    end
  end

  // ****************************************
  // register port and pin outputs
  // ****************************************
  logic rd_reg;
  logic wr_reg;
  logic [HPP_AW-1:0] addr_reg;
  logic [HPP_AW-1:0] addr_next;
  logic [HPP_DW-1:0] wdata_reg;
  logic [HPP_DW-1:0] wdata_next;
  logic pin_reg;
  logic pin_next;

  // merge both sources onto one access port
  always_comb
  begin
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (par_rd || par_wr)
    begin
      addr_next = cur_addr;
      wdata_next = s.data;
    end
    else if (ser_rd || ser_wr)
    begin
      addr_next = ser_addr;
      wdata_next = sh_new[HPP_DW-1:0];
    end
    // acknowledge active low, ready active high
    if (!par_mode)
    begin
      pin_next = sdo_next;
    end
    else
    begin
      pin_next = dstb_style ? ~resp_next : resp_next;
    end
  end

  // output registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      pin_reg <= 1'b0;
    end
    else
    begin
      rd_reg <= par_rd | ser_rd;
      wr_reg <= par_wr | ser_wr;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      pin_reg <= pin_next;
    end
  end

  assign reg_rd = rd_reg;
  assign reg_wr = wr_reg;
  assign reg_addr = addr_reg;
  assign reg_wdata = wdata_reg;
  assign pins.serial_out_resp = pin_reg;
  assign pins.dev_d_o = dout_reg;
  assign pins.dev_d_oe = oe_reg;

endmodule : hpp_device_end

// file: rtl/hpp_host_end.sv
`timescale 1ns/1ps
// ****************************************
// bus master driving the device pins
// ****************************************
module hpp_host_end
  import hpp_pkg::*;
#(
  parameter int HALF_CYC = HPP_HALF_CYC
)
(
  hpp_if.host pins,
  input logic clk,
  input logic rst,
  input logic cfg_parallel,
  input logic cfg_strobe_pair,
  input logic cfg_mux,
  input logic cmd_valid,
  input logic cmd_write,
  input logic [HPP_AW-1:0] cmd_addr,
  input logic [HPP_DW-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [HPP_DW-1:0] rsp_rdata
);

  localparam logic [7:0] TMR_LAST = 8'(HALF_CYC - 1);

  // two flops on device outputs
  logic [HPP_DW:0] in1_reg;
  logic [HPP_DW:0] in2_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in1_reg <= '0;
      in2_reg <= '0;
    end
    else
    begin
      in1_reg <= {pins.serial_out_resp, pins.data_bus};
      in2_reg <= in1_reg;
    end
  end

  hpp_host_state_e st_reg, st_next;
  logic [7:0] tmr_reg, tmr_next;
  logic [4:0] cnt_reg, cnt_next;
  logic cs_reg, cs_next, as_reg, as_next, stb_reg, stb_next, dir_reg, dir_next;
  logic ps_reg, ps_next, sty_reg, sty_next, mux_reg, mux_next;
  logic doe_reg, doe_next, wr_reg, wr_next, rdy_reg, rdy_next, rv_reg, rv_next;
  logic [HPP_AW-1:0] addr_reg, addr_next;
  logic [HPP_DW-1:0] dout_reg, dout_next, rdat_reg, rdat_next, rsh_reg, rsh_next;
  logic [HPP_SER_ALL-1:0] sh_reg, sh_next, word;
  logic tmr_done, resp_on, dstb;

  // sequencing of every access style
  always_comb
  begin
    tmr_done = (tmr_reg == TMR_LAST);
    dstb = (sty_reg == HPP_STYLE_DSTB);
    resp_on = dstb ? ~in2_reg[HPP_DW] : in2_reg[HPP_DW];
    word = {cmd_write ? ~HPP_SER_READ : HPP_SER_READ, cmd_addr, cmd_write ? cmd_wdata : 8'h00};
    {st_next, cnt_next, cs_next, as_next, stb_next, dir_next} = {st_reg, cnt_reg, cs_reg, as_reg, stb_reg, dir_reg};
    {ps_next, sty_next, mux_next, doe_next, wr_next} = {ps_reg, sty_reg, mux_reg, doe_reg, wr_reg};
    {addr_next, dout_next, rdat_next, rsh_next, sh_next} = {addr_reg, dout_reg, rdat_reg, rsh_reg, sh_reg};
    tmr_next = tmr_done ? 8'h00 : tmr_reg + 8'h01;
    rdy_next = 1'b0;
    rv_next = 1'b0;
    case (st_reg)
      HPP_H_IDLE:
      begin
        tmr_next = 8'h00;
        ps_next = cfg_parallel;
        sty_next = cfg_strobe_pair;
        mux_next = cfg_parallel & cfg_mux;
        cs_next = 1'b1;
        as_next = cfg_parallel & ~cfg_mux;
        stb_next = cfg_parallel;
        dir_next = cfg_parallel;
        doe_next = ~cfg_parallel;
        dout_next = 8'h00;
        addr_next = '0;
        rdy_next = 1'b1;
        if (cmd_valid && rdy_reg)
        begin
          // chip select low opens the access
          rdy_next = 1'b0;
          wr_next = cmd_write;
          cs_next = 1'b0;
          cnt_next = 5'h00;
          if (!cfg_parallel)
          begin
            dir_next = word[HPP_SER_ALL-1];
            sh_next = {word[HPP_SER_ALL-2:0], 1'b0};
            st_next = HPP_H_SER;
          end
          else
          begin
            if (cfg_strobe_pair == HPP_STYLE_DSTB)
            begin
              dir_next = ~cmd_write;
            end
            if (cfg_mux)
            begin
              addr_next = {cmd_addr[HPP_AW-1:HPP_MUX_HI], 8'h00};
              // low address byte driven on the data lines
              doe_next = 1'b1;
              dout_next = cmd_addr[HPP_DW-1:0];
              as_next = 1'b1;
              st_next = HPP_H_ADDR;
            end
            else
            begin
              addr_next = cmd_addr;
              doe_next = cmd_write;
              dout_next = cmd_wdata;
              st_next = HPP_H_DATA;
            end
          end
        end
      end
      HPP_H_ADDR:
      begin
        if (tmr_done)
        begin
          as_next = 1'b0;
          st_next = HPP_H_LATCH;
        end
      end
      HPP_H_LATCH:
      begin
        if (tmr_done)
        begin
          doe_next = wr_reg;
          dout_next = cmd_wdata;
          st_next = HPP_H_DATA;
        end
      end
      HPP_H_DATA:
      begin
        if (tmr_done)
        begin
          stb_next = dstb | wr_reg ? ~dstb : 1'b0;
          dir_next = dstb ? dir_reg : ~wr_reg;
          st_next = HPP_H_STROBE;
        end
      end
      HPP_H_STROBE:
      begin
        tmr_next = 8'h00;
        if (resp_on)
        begin
          rdat_next = in2_reg[HPP_DW-1:0];
          rv_next = 1'b1;
          cs_next = 1'b1;
          stb_next = 1'b1;
          dir_next = dstb ? dir_reg : 1'b1;
          doe_next = 1'b0;
          st_next = HPP_H_END;
        end
      end
      HPP_H_END:
      begin
        if (tmr_done && (!ps_reg || !resp_on))
        begin
          st_next = HPP_H_IDLE;
        end
      end
      HPP_H_SER:
      begin
        if (tmr_done && !stb_reg)
        begin
          stb_next = 1'b1;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg >= HPP_SER_HDR)
          begin
            rsh_next = {rsh_reg[HPP_DW-2:0], in2_reg[HPP_DW]};
          end
        end
        else if (tmr_done)
        begin
          stb_next = 1'b0;
          if (cnt_reg == HPP_SER_ALL)
          begin
            cs_next = 1'b1;
            rdat_next = rsh_reg;
            rv_next = 1'b1;
            st_next = HPP_H_END;
          end
          else
          begin
            dir_next = sh_reg[HPP_SER_ALL-1];
            sh_next = {sh_reg[HPP_SER_ALL-2:0], 1'b0};
          end
        end
      end
      default:
      begin
        st_next = HPP_H_IDLE;
      end
    endcase
  end

  // host state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {st_reg, tmr_reg, cnt_reg} <= {HPP_H_IDLE, 8'h00, 5'h00};
      {cs_reg, as_reg, stb_reg, dir_reg} <= 4'hF;
      {ps_reg, sty_reg, mux_reg, doe_reg, wr_reg, rdy_reg, rv_reg} <= 7'h00;
      {addr_reg, dout_reg, rdat_reg, rsh_reg, sh_reg} <= '0;
    end
    else
    begin
      {st_reg, tmr_reg, cnt_reg} <= {st_next, tmr_next, cnt_next};
      {cs_reg, as_reg, stb_reg, dir_reg} <= {cs_next, as_next, stb_next, dir_next};
      {ps_reg, sty_reg, mux_reg, doe_reg, wr_reg, rdy_reg, rv_reg} <=
        {ps_next, sty_next, mux_next, doe_next, wr_next, rdy_next, rv_next};
      {addr_reg, dout_reg, rdat_reg, rsh_reg, sh_reg} <= {addr_next, dout_next, rdat_next, rsh_next, sh_next};
    end
  end

  assign pins.cs_n = cs_reg;
  assign pins.port_style_sel = ps_reg;
  assign pins.bus_style_select = sty_reg;
  assign pins.mux_bus_select = mux_reg;
  assign pins.address_strobe_n = as_reg;
  assign pins.clk_strobe = stb_reg;
  assign pins.serial_in_dir = dir_reg;
  assign pins.addr = addr_reg;
  assign pins.host_d_o = dout_reg;
  assign pins.host_d_oe = doe_reg;
  assign cmd_ready = rdy_reg;
  assign rsp_valid = rv_reg;
  assign rsp_rdata = rdat_reg;

endmodule : hpp_host_end

// file: tb/hpp_pins_asserts.sv
`timescale 1ns/1ps
// ****************************************
// pin rule checker
// ****************************************
module hpp_pins_asserts
  import hpp_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic cs_n,
  input logic port_style_sel,
  input logic bus_style_select,
  input logic mux_bus_select,
  input logic address_strobe_n,
  input logic clk_strobe,
  input logic serial_in_dir,
  input logic serial_out_resp,
  input logic [HPP_AW-1:0] addr,
  input logic dev_d_oe,
  input logic [HPP_DW-1:0] data_bus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic pair_m;
  logic dstb_m;
  // selected parallel access in each style
  assign pair_m = port_style_sel && bus_style_select && !cs_n;
  assign dstb_m = port_style_sel && !bus_style_select && !cs_n;

  a_drive_only_read: assert property ($rose(dev_d_oe) |-> !cs_n && port_style_sel && serial_in_dir)
    else $error("data bus driven outside a read");
  a_release_bus: assert property ($rose(cs_n) |-> ##[0:6] !dev_d_oe)
    else $error("data bus kept after deselect");
  a_ready_read: assert property ($fell(clk_strobe) && pair_m |-> ##[2:7] serial_out_resp)
    else $error("ready missing on read");
  a_ready_write: assert property ($fell(serial_in_dir) && pair_m |-> ##[2:7] serial_out_resp)
    else $error("ready missing on write");
  a_ack_strobe: assert property ($fell(clk_strobe) && dstb_m |-> ##[2:7] !serial_out_resp)
    else $error("acknowledge missing");
  a_read_drives_data: assert property (((pair_m && serial_out_resp) || (dstb_m && serial_in_dir && !serial_out_resp))
    && !clk_strobe |-> dev_d_oe)
    else $error("read answered without data");
  a_ack_idle_high: assert property ((port_style_sel && !bus_style_select && clk_strobe) [*8] |-> serial_out_resp)
    else $error("acknowledge low while idle");
  a_ready_idle_low: assert property ((port_style_sel && bus_style_select && clk_strobe && serial_in_dir) [*8]
    |-> !serial_out_resp)
    else $error("ready high while idle");
  a_sep_strobe_high: assert property (port_style_sel && !mux_bus_select && !cs_n |-> address_strobe_n)
    else $error("address strobe low on separate bus");
  a_mux_low_zero: assert property (port_style_sel && mux_bus_select && !cs_n |-> addr[7:0] == 8'h00)
    else $error("low address lines not grounded");
  a_serial_ties: assert property (!port_style_sel && !cs_n
    |-> data_bus == 8'h00 && !mux_bus_select && !address_strobe_n)
    else $error("parallel pins not grounded in serial");
  a_ser_in_stable: assert property (!port_style_sel && !cs_n && $rose(clk_strobe) |-> $stable(serial_in_dir))
    else $error("serial input moved at rising shift clock");
  a_ser_out_fall: assert property ($changed(serial_out_resp) && !port_style_sel && !$past(port_style_sel, 8)
    |-> !clk_strobe)
    else $error("serial output moved while shift clock high");

  c_pair_read: cover property (pair_m && serial_out_resp && dev_d_oe);
  c_dstb_ack: cover property (dstb_m && !serial_out_resp);
  c_ser_bit: cover property (!port_style_sel && !cs_n && $rose(clk_strobe));
  c_mux_latch: cover property ($fell(address_strobe_n) && mux_bus_select);
endmodule : hpp_pins_asserts

// file: tb/host_processor_port_tb.sv
`timescale 1ns/1ps
// ****************************************
// host and device ends joined back to back
// ****************************************
module host_processor_port_tb;
  import hpp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // parallel, strobe pair, multiplexed
  logic [2:0] cfg = 3'h0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [HPP_AW-1:0] cmd_addr = 11'h000;
  logic [HPP_DW-1:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, reg_rd, reg_wr, sclk_q, ale_q;
  logic [HPP_DW-1:0] rsp_rdata, reg_wdata, reg_rdata, wd, ale_byte;
  logic [HPP_AW-1:0] reg_addr, wa;
  logic [19:0] frame;
  logic [2:0] modes [5] = '{3'h0, 3'h6, 3'h7, 3'h4, 3'h5};
  int miscompares = 0;
  int checks_done = 0;
  int wr_count = 0;

  always #4 clk = ~clk;

  hpp_if u_hpp_if();
  hpp_host_end #(.HALF_CYC(8)) u_hpp_host_end (.pins(u_hpp_if.host), .clk(clk), .rst(rst), .cfg_parallel(cfg[2]),
    .cfg_strobe_pair(cfg[1]), .cfg_mux(cfg[0]), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpp_device_end u_hpp_device_end (.pins(u_hpp_if.device), .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  hpp_pins_asserts u_hpp_pins_asserts (.clk(clk), .rst(rst), .cs_n(u_hpp_if.cs_n),
    .port_style_sel(u_hpp_if.port_style_sel), .bus_style_select(u_hpp_if.bus_style_select),
    .mux_bus_select(u_hpp_if.mux_bus_select), .address_strobe_n(u_hpp_if.address_strobe_n),
    .clk_strobe(u_hpp_if.clk_strobe), .serial_in_dir(u_hpp_if.serial_in_dir),
    .serial_out_resp(u_hpp_if.serial_out_resp), .addr(u_hpp_if.addr), .dev_d_oe(u_hpp_if.dev_d_oe),
    .data_bus(u_hpp_if.data_bus));

  // register stand-in: read value follows the address
  function automatic logic [7:0] rd_val(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction : rd_val
  assign reg_rdata = rd_val(reg_addr);

  // wire monitors: serial bits, latched address byte, register writes
  always @(posedge clk)
  begin
    sclk_q <= u_hpp_if.clk_strobe;
    ale_q <= u_hpp_if.address_strobe_n;
    if (!sclk_q && u_hpp_if.clk_strobe && !u_hpp_if.cs_n)
    begin
      frame <= {frame[18:0], u_hpp_if.serial_in_dir};
    end
    if (ale_q && !u_hpp_if.address_strobe_n)
    begin
      ale_byte <= u_hpp_if.data_bus;
    end
    if (reg_wr)
    begin
      wa <= reg_addr;
      wd <= reg_wdata;
      wr_count <= wr_count + 1;
    end
  end

  // compare one value
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // counts and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // one access through the host command port
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    int wc;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      miscompares++;
      close_out();
    end
    wc = wr_count;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 6000);
    if (n >= 6000)
    begin
      miscompares++;
      close_out();
    end
    if (w)
    begin
      check(20'(wr_count - wc), 20'h00001);
      check({9'h000, wa}, {9'h000, a});
      check({12'h000, wd}, {12'h000, d});
      if (!cfg[2]) check(frame, {1'b0, a, d});
    end
    else
    begin
      check({12'h000, rsp_rdata}, {12'h000, rd_val(a)});
      check(20'(wr_count - wc), 20'h00000);
    end
    if (cfg[2] && cfg[0]) check({12'h000, ale_byte}, {12'h000, a[7:0]});
  endtask : xfer

  // every port style, boundary addresses, accesses back to back
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk);
      cfg <= modes[m];
      repeat (8) @(posedge clk);
      xfer(1'b1, 11'h7FF, 8'h5A);
      xfer(1'b1, 11'h0C3, 8'hA5);
      xfer(1'b0, 11'h7FF, 8'h00);
      xfer(1'b0, 11'h12C, 8'h00);
      $display("test mode %0d done", m);
    end
    close_out();
  end
endmodule : host_processor_port_tb
